//--- verilog/tefm_flag_mask_unit.sv
// Functional notes
// RULE1 - flag and mask words byte or word accessible
// RULE2 - both words reset to zero
// RULE3 - enabled set flag raises interrupt request
// RULE4 - flag word layout, unused bits read zero
// RULE5 - counter equals compare value sets flag
// RULE6 - selected capture edge sets flag
// RULE7 - shared flag follows capture or compare-5 function
// RULE8 - counter rollover sets wrap flag
// RULE9 - accumulator rollover sets accumulator wrap flag
// RULE10 - event mode: active edge sets event flag
// RULE11 - gated mode: period end sets event flag
// RULE12 - no request when enable bit clear
// RULE13 - flags set regardless of enables
// RULE14 - uncleared enabled flag keeps request pending
// RULE15 - mask word layout, bit six zero
// RULE16 - low mask nibble drives prescaler select
// RULE17 - shared enable gates active shared function
// RULE18 - clear needs read-while-set then zero write
// RULE19 - new event between read and clear keeps flag
// RULE20 - software writes never set flags
// RULE21 - request is OR of flag AND enable
`timescale 1ns/1ps
module tefm_flag_mask_unit
  import tefm_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int ACC_W = 8
) (
  input wire logic clk_i, // module clock, 20 MHz
  input wire logic rst_n_i, // sync reset, active low
  input tefm_bus_s bus_i, // register access
  output logic [15:0] rdata_o, // read data
  output logic ack_o, // access answered
  input wire logic [CNT_W-1:0] free_run_counter_i, // timer count
  input wire logic [NUM_CMP-1:0][CNT_W-1:0] cmp_val_i, // compare 1..4 values
  input wire logic [CNT_W-1:0] cmp5_val_i, // compare 5 value
  input wire logic [NUM_CAP-1:0] cap_edge_i, // selected capture edges
  input wire logic ch45_edge_i, // selected edge on shared pin
  input wire logic ch45_is_capture_i, // shared pin used for capture
  input wire logic [ACC_W-1:0] accum_count_i, // accumulator counter
  input wire logic accum_input_pin_i, // accumulator input pin
  input wire logic accum_active_high_i, // active input polarity
  input wire logic accum_gated_mode_i, // accumulator mode select
  output tefm_presc_s presc_o, // prescaler controls
  output logic irq_o, // module interrupt request
  output logic [15:0] pending_o // flag AND enable per bit
);

  logic [15:0] event_flags;
  logic [15:0] enable_mask;
  logic [15:0] armed; // flags read while set, eligible for clearing
  logic [15:0] rdata;
  logic ack;
  tefm_evt_s evt;

  tefm_event_detect #(
    .CNT_W(CNT_W),
    .ACC_W(ACC_W)
  ) u_detect (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .free_run_counter_i(free_run_counter_i),
    .cmp_val_i(cmp_val_i),
    .cmp5_val_i(cmp5_val_i),
    .cap_edge_i(cap_edge_i),
    .ch45_edge_i(ch45_edge_i),
    .ch45_is_capture_i(ch45_is_capture_i),
    .accum_count_i(accum_count_i),
    .accum_input_pin_i(accum_input_pin_i),
    .accum_active_high_i(accum_active_high_i),
    .accum_gated_mode_i(accum_gated_mode_i),
    .evt_o(evt)
  );

  tefm_irq_combine u_irq (
    .flags_i(event_flags),
    .enables_i(enable_mask),
    .irq_o(irq_o),
    .pending_o(pending_o)
  );

  // byte-lane mask from the two byte enables
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  wire hit_mask = (bus_i.addr == MASK_ADDR);
  wire hit_flag = (bus_i.addr == FLAG_ADDR);
  wire [15:0] lanes = lane_mask(bus_i.be); // RULE1
  wire mask_wr = bus_i.wr && hit_mask;
  wire flag_wr = bus_i.wr && hit_flag;
  wire flag_rd = bus_i.rd && hit_flag;

  // event word in flag positions; enables are not consulted
  wire [15:0] set_vec = {
    evt.ch45_cap_edge | evt.ch45_cmp_match, // RULE7
    evt.cmp_match[3], evt.cmp_match[2], evt.cmp_match[1], evt.cmp_match[0],
    evt.cap_edge[2], evt.cap_edge[1], evt.cap_edge[0],
    evt.cnt_wrap, 1'b0, evt.acc_wrap, evt.acc_event, 4'h0
  } & FLAG_IMPL; // RULE4 RULE13

  // zero written into an armed, enabled lane clears; ones are ignored
  wire [15:0] clr_vec = flag_wr ? (lanes & ~bus_i.wdata & armed) : 16'h0000; // RULE18 RULE20

  // set wins over clear, so a fresh event survives the clearing write
  wire [15:0] next_event_flags = (event_flags & ~clr_vec) | set_vec; // RULE19

  wire [15:0] next_enable_mask = mask_wr
    ? ((enable_mask & ~lanes) | (bus_i.wdata & lanes & MASK_IMPL)) // RULE15
    : enable_mask;

  // a read arms only bits that were set and on the lanes read;
  // a fresh set after the read is not armed, so it cannot be lost
  wire [15:0] rd_arm = flag_rd ? (event_flags & lanes) : 16'h0000; // RULE18
  wire [15:0] next_armed = ((armed & ~clr_vec) | rd_arm) & ~set_vec; // RULE19

  wire [15:0] read_word = hit_flag ? (event_flags & FLAG_IMPL) // RULE4
                        : hit_mask ? (enable_mask & MASK_IMPL) // RULE15
                        : 16'h0000;
  wire [15:0] next_rdata = bus_i.rd ? (read_word & lanes) : rdata; // RULE1

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      event_flags <= FLAG_RESET; // RULE2
      enable_mask <= MASK_RESET; // RULE2
      armed <= 16'h0000;
      rdata <= 16'h0000;
      ack <= 1'b0;
    end else begin
      event_flags <= next_event_flags;
      enable_mask <= next_enable_mask;
      armed <= next_armed;
      rdata <= next_rdata;
      ack <= bus_i.rd || bus_i.wr;
    end
  end

  assign rdata_o = rdata;
  assign ack_o = ack;
  assign presc_o = enable_mask[3:0]; // RULE16

endmodule : tefm_flag_mask_unit

//--- verilog/tefm_pkg.sv
package tefm_pkg;

  // register byte addresses within the module window
  localparam logic [15:0] MASK_ADDR = 16'hF920;
  localparam logic [15:0] FLAG_ADDR = 16'hF922;

  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] FLAG_RESET = 16'h0000;

  // flag and enable positions, shared by both words
  localparam int BIT_CH45 = 15;
  localparam int BIT_CMP4 = 14;
  localparam int BIT_CMP1 = 11;
  localparam int BIT_CAP3 = 10;
  localparam int BIT_CAP1 = 8;
  localparam int BIT_WRAP = 7;
  localparam int BIT_ACOV = 5;
  localparam int BIT_ACEV = 4;

  // implemented bits of each word
  localparam logic [15:0] FLAG_IMPL = 16'hFFB0;
  localparam logic [15:0] MASK_IMPL = 16'hFFBF;
  localparam logic [15:0] IRQ_SRC = 16'hFFB0;

  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0] ACC_MAX = 8'hFF;

  localparam int NUM_CMP = 4;
  localparam int NUM_CAP = 3;

  // one register-bus access
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [1:0] be;
    logic [15:0] wdata;
  } tefm_bus_s;

  // one clock of hardware events
  typedef struct packed {
    logic [NUM_CMP-1:0] cmp_match;
    logic [NUM_CAP-1:0] cap_edge;
    logic ch45_cap_edge;
    logic ch45_cmp_match;
    logic ch45_is_capture;
    logic cnt_wrap;
    logic acc_wrap;
    logic acc_event;
  } tefm_evt_s;

  // prescaler controls held in the low mask nibble
  typedef struct packed {
    logic prescaler_out_select;
    logic [2:0] prescale_select;
  } tefm_presc_s;

  typedef enum logic [1:0] {
    ACC_EVENT_COUNT = 2'h1,
    ACC_GATED_TIME = 2'h2
  } tefm_accmode_e;

endpackage : tefm_pkg

//--- verilog/tefm_event_detect.sv
`timescale 1ns/1ps
module tefm_event_detect
  import tefm_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int ACC_W = 8
) (
  input wire logic clk_i, // module clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic [CNT_W-1:0] free_run_counter_i, // timer count
  input wire logic [NUM_CMP-1:0][CNT_W-1:0] cmp_val_i, // compare 1..4 values
  input wire logic [CNT_W-1:0] cmp5_val_i, // compare 5 value
  input wire logic [NUM_CAP-1:0] cap_edge_i, // selected capture edges 1..3
  input wire logic ch45_edge_i, // selected edge on shared pin
  input wire logic ch45_is_capture_i, // shared pin used for capture
  input wire logic [ACC_W-1:0] accum_count_i, // accumulator counter
  input wire logic accum_input_pin_i, // accumulator input level
  input wire logic accum_active_high_i, // active level/edge of input
  input wire logic accum_gated_mode_i, // 1 gated time, 0 event count
  output tefm_evt_s evt_o // events of this clock
);

  logic [CNT_W-1:0] cnt_prev;
  logic [ACC_W-1:0] acc_prev;
  logic pin_prev;

  // compare only on a counter change, so one match sets its flag once
  wire cnt_moved = (free_run_counter_i != cnt_prev);
  wire pin_act = (accum_input_pin_i == accum_active_high_i);
  wire prev_act = (pin_prev == accum_active_high_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_prev <= '0;
      acc_prev <= '0;
      pin_prev <= 1'b0;
    end else begin
      cnt_prev <= free_run_counter_i;
      acc_prev <= accum_count_i;
      pin_prev <= accum_input_pin_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : g_cmp
      assign evt_o.cmp_match[g] = cnt_moved && (free_run_counter_i == cmp_val_i[g]); // RULE5
    end
  endgenerate

  assign evt_o.cap_edge = cap_edge_i; // RULE6
  assign evt_o.ch45_cap_edge = ch45_is_capture_i && ch45_edge_i; // RULE7
  assign evt_o.ch45_cmp_match = !ch45_is_capture_i && cnt_moved
    && (free_run_counter_i == cmp5_val_i); // RULE7
  assign evt_o.ch45_is_capture = ch45_is_capture_i;
  assign evt_o.cnt_wrap = (cnt_prev == CNT_MAX[CNT_W-1:0]) && (free_run_counter_i == '0); // RULE8
  assign evt_o.acc_wrap = (acc_prev == ACC_MAX[ACC_W-1:0]) && (accum_count_i == '0); // RULE9
  // event count: entering active; gated: leaving active ends the period
  assign evt_o.acc_event = accum_gated_mode_i ? (prev_act && !pin_act) // RULE11
                                              : (!prev_act && pin_act); // RULE10

endmodule : tefm_event_detect

//--- verilog/tefm_irq_combine.sv
`timescale 1ns/1ps
module tefm_irq_combine
  import tefm_pkg::*;
(
  input wire logic [15:0] flags_i, // event flag word
  input wire logic [15:0] enables_i, // enable mask word
  output logic irq_o, // module request
  output logic [15:0] pending_o // pending sources
);

  // prescaler nibble never reaches the request
  assign pending_o = flags_i & enables_i & IRQ_SRC; // RULE3 RULE12 RULE17
  assign irq_o = |pending_o; // RULE21 RULE14

endmodule : tefm_irq_combine

//--- test/tefm_flag_mask_chk.sv
`timescale 1ns/1ps
module tefm_flag_mask_chk
  import tefm_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input tefm_bus_s bus_i, // access
  input wire logic [15:0] rdata_o, // read data
  input wire logic ack_o, // answer
  input wire logic [NUM_CAP-1:0] cap_edge_i, // edges
  input tefm_presc_s presc_o, // prescaler
  input wire logic irq_o, // request
  input wire logic [15:0] pending_o // pending
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire mapped = bus_i.addr == MASK_ADDR || bus_i.addr == FLAG_ADDR;
  property p_ack; bus_i.rd || bus_i.wr |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_irq; irq_o == (pending_o != 16'h0000); endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_pend; (pending_o & ~IRQ_SRC) == 16'h0000; endproperty
  a_pend: assert property (p_pend) else $error("bad pending");
  property p_cap; $rose(pending_o[BIT_CAP1]) |-> $past(cap_edge_i[0]) || $past(bus_i.wr); endproperty
  a_cap: assert property (p_cap) else $error("set w/o cause");
  property p_fall; $fell(pending_o[BIT_CAP1]) |-> $past(bus_i.wr); endproperty
  a_fall: assert property (p_fall) else $error("lost flag");
  property p_presc; bus_i.wr && bus_i.addr == MASK_ADDR && bus_i.be[0]
    |=> presc_o == $past(bus_i.wdata[3:0]); endproperty
  a_presc: assert property (p_presc) else $error("presc");
  property p_unmap; bus_i.rd && !mapped |=> rdata_o == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_rsvd; bus_i.rd |=> !rdata_o[6]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bit6 set");
  c_rise: cover property ($rose(irq_o));
  c_fall: cover property ($fell(irq_o));
  c_unmap: cover property (bus_i.rd && !mapped);
endmodule : tefm_flag_mask_chk
bind tefm_flag_mask_unit tefm_flag_mask_chk i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .ack_o(ack_o), .cap_edge_i(cap_edge_i),
  .presc_o(presc_o), .irq_o(irq_o), .pending_o(pending_o));

//--- test/tefm_cpu_model.sv
`timescale 1ns/1ps
module tefm_cpu_model
  import tefm_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic ack_i, // answer
  input wire logic [15:0] rdata_i, // read data
  output tefm_bus_s bus_o // access
);
  initial bus_o = '0;
  // strobe lasts one edge; the answer is taken just after that same edge
  task automatic acc(input logic [15:0] a, input logic w, input logic [1:0] be,
    input logic [15:0] d, output logic [15:0] q, output logic ok);
    @(posedge clk_i);
    #1 bus_o = '{a, !w, w, be, d};
    @(posedge clk_i);
    #1 bus_o.rd = 1'b0;
    bus_o.wr = 1'b0;
    ok = ack_i;
    q = rdata_i;
  endtask : acc
  task automatic clr(input logic [15:0] m);
    logic [15:0] q;
    logic ok;
    acc(FLAG_ADDR, 1'b0, 2'b11, 16'h0000, q, ok);
    acc(FLAG_ADDR, 1'b1, 2'b11, ~m, q, ok);
  endtask : clr
endmodule : tefm_cpu_model

//--- test/tb_timer_event_flag_mask_unit.sv
`timescale 1ns/1ps
module tb_timer_event_flag_mask_unit;
  import tefm_pkg::*;
  logic clk_i = 0;
  logic rst_n_i = 0;
  tefm_bus_s bus;
  tefm_presc_s presc;
  logic [15:0] rdata, pend, q, cnt = '0, c5 = 16'h000E;
  logic [NUM_CMP-1:0][15:0] cmp = {16'h000D, 16'h000C, 16'h000B, 16'h000A};
  logic [2:0] cap = '0;
  logic [7:0] acc = '0;
  logic ack, irq, e45 = 0, is_cap = 0, pin = 0, hi = 1, gated = 0;
  int n_mismatch = 0;
  int checks_done = 0;
  always #25 clk_i = ~clk_i;
  tefm_cpu_model i_cpu (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata), .bus_o(bus));
  tefm_flag_mask_unit i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus),
    .rdata_o(rdata), .ack_o(ack), .free_run_counter_i(cnt), .cmp_val_i(cmp),
    .cmp5_val_i(c5), .cap_edge_i(cap), .ch45_edge_i(e45), .ch45_is_capture_i(is_cap),
    .accum_count_i(acc), .accum_input_pin_i(pin), .accum_active_high_i(hi),
    .accum_gated_mode_i(gated), .presc_o(presc), .irq_o(irq), .pending_o(pend));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic xfer(input logic [15:0] a, input logic w, input logic [1:0] be,
    input logic [15:0] d);
    logic ok;
    i_cpu.acc(a, w, be, d, q, ok);
    chk("ack", 16'h0001, {15'h0000, ok});
  endtask : xfer
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick
  initial begin
    #100000 n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rst_n_i = 1;
    xfer(MASK_ADDR, 0, 2'b11, 0); chk("mask", MASK_RESET, q);
    xfer(FLAG_ADDR, 0, 2'b11, 0); chk("flags", FLAG_RESET, q);
    xfer(16'hF924, 0, 2'b11, 0); chk("unmapped", 16'h0000, q);
    // every source fires with all enables clear
    tick; cap = 3'b111; tick; cap = '0;
    for (int i = 9; i <= 14; i++) begin
      tick; cnt = 16'(i);
    end
    tick; cnt = 16'hFFFF; tick; cnt = '0;
    tick; acc = 8'hFF; tick; acc = '0;
    tick; pin = 1; tick; tick;
    chk("irq idle", 16'h0000, {15'h0000, irq});
    xfer(FLAG_ADDR, 1, 2'b11, 16'h0000);
    xfer(FLAG_ADDR, 0, 2'b11, 0); chk("flags all", 16'hFFB0, q);
    xfer(MASK_ADDR, 1, 2'b01, 16'hFFFF);
    xfer(MASK_ADDR, 0, 2'b11, 0); chk("mask lo", 16'h00BF, q);
    chk("presc", 16'h000F, {12'h000, presc});
    chk("pending", 16'h00B0, pend);
    xfer(FLAG_ADDR, 1, 2'b11, 16'hFFFF);
    chk("irq held", 16'h0001, {15'h0000, irq});
    tick; cap = 3'b001; tick; cap = '0;
    xfer(FLAG_ADDR, 1, 2'b11, 16'h0000);
    chk("irq off", 16'h0000, {15'h0000, irq});
    xfer(FLAG_ADDR, 0, 2'b10, 0); chk("flags hi", 16'h0100, q);
    xfer(FLAG_ADDR, 1, 2'b11, 16'hFFFF);
    xfer(FLAG_ADDR, 0, 2'b11, 0); chk("no set", 16'h0100, q);
    is_cap = 1; gated = 1;
    xfer(MASK_ADDR, 1, 2'b10, 16'h8100);
    tick; e45 = 1; pin = 0; tick; e45 = 0; tick;
    chk("shared", 16'h8110, pend);
    i_cpu.clr(16'h0100);
    chk("cleared", 16'h8010, pend);
    wrap_up();
  end
endmodule : tb_timer_event_flag_mask_unit
